/* rsc_map.vh */
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define RSC_CLK_PERIOD_NS     50
`define RSC_EXT_MIN_PULSE_NS  50
`define RSC_BOD_MIN_NS        2000

// least times round up to whole cycles; any nonzero time gives at least one cycle
`define RSC_EXT_MIN_CYC ((`RSC_EXT_MIN_PULSE_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_BOD_MIN_CYC ((`RSC_BOD_MIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RSC_CTRL_OFS    8'h00
`define RSC_STATUS_OFS  8'h04
`define RSC_COUNT_OFS   8'h08
`define RSC_TARGET_OFS  8'h0c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RSC_CTRL_WDT_EN_BIT   0
`define RSC_CTRL_BOD_EN_BIT   1
`define RSC_ST_REQ_LSB        0
`define RSC_ST_REQ_MSB        4
`define RSC_ST_SYSRST_BIT     5
`define RSC_ST_STATE_LSB      6
`define RSC_ST_STATE_MSB      7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RSC_CTRL_RST          2'h0
`define RSC_RESET_VECTOR      16'h0000

`endif

/* rsc_sync.v */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// two flip-flop synchroniser for a group of asynchronous levels
// ----------------------------------------------------------------------
module rsc_sync
#(
    parameter WIDTH    = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
    // clock, reset, enable
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             clk_en,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // first stage feeds only the second stage
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else if (clk_en)
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

/* rsc_reset_ctrl.v */
// Summary of operation
// - internal reset returns every I/O register to its initial value; here ctrl_r clears only on rst, not on sys_reset
// - on release, instruction fetch starts at the reset vector
// - I/O pins forced to initial state as soon as any request goes active; here io_force is registered and trails a pin by about four cycles
// - delay counter starts only after all requests inactive; reset held till expiry
// - stretch length chosen by the delay-select fuses
// - five request sources: power-on, pin, watchdog, brown-out, scan reset bit
// - pin low longer than about 50 ns requests reset
// - watchdog requests only when enabled and its timeout elapses
// - brown-out requests only when enabled and supply low beyond about 2 us
// - reset held while the scan-chain reset bit holds one
// - power-on request active while supply below detection level
// - supply rising past threshold starts the stretch counter
// - supply falling below detection level reasserts reset at once; here sys_reset rises about three cycles later, behind the synchroniser
// - watchdog timeout gives a one-cycle pulse; stretch starts after it
// - after pin reset, counter starts on pin release, releases after timeout
`timescale 1ns/1ps
`include "rsc_map.vh"

module rsc_reset_ctrl
#(
    parameter CNT_W    = 20,
    parameter DLY_SEL0 = 16,
    parameter DLY_SEL1 = 1024,
    parameter DLY_SEL2 = 16384,
    parameter DLY_SEL3 = 65536
)
(
    // clock, reset, enable
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        clk_en,
    // reset request sources, asynchronous
    input  wire        por_below,
    input  wire        ext_reset_n,
    input  wire        wdt_timeout,
    input  wire        bod_below,
    input  wire        scan_reset_bit,
    // delay selection, static nonvolatile setting
    input  wire [1:0]  delay_select_fuses,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // reset outputs
    output reg         sys_reset,
    output reg         io_force,
    output reg         fetch_start,
    output reg  [15:0] fetch_addr
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam [1:0] ST_HOLD    = 2'd0;
    localparam [1:0] ST_STRETCH = 2'd1;
    localparam [1:0] ST_RUN     = 2'd2;

    // filter lengths in whole cycles, cut to the counter width on purpose
    localparam integer EXT_MIN_I = `RSC_EXT_MIN_CYC;
    localparam integer BOD_MIN_I = `RSC_BOD_MIN_CYC;
    localparam [7:0]   EXT_MIN   = EXT_MIN_I[7:0];
    localparam [7:0]   BOD_MIN   = BOD_MIN_I[7:0];

    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    wire [4:0] sync_lvl;
    wire       por_s;
    wire       ext_n_s;
    wire       wdt_s;
    wire       bod_s;
    wire       scan_s;

    // power-on assumed low-supply and pin assumed released at reset
    rsc_sync #(
        .WIDTH   (5),
        .RST_VAL (5'h03)
    ) rsc_sync_i (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in ({scan_reset_bit, bod_below, wdt_timeout, ext_reset_n, por_below}),
        .sync_out (sync_lvl)
    );

    assign por_s   = sync_lvl[0];
    assign ext_n_s = sync_lvl[1];
    assign wdt_s   = sync_lvl[2];
    assign bod_s   = sync_lvl[3];
    assign scan_s  = sync_lvl[4];

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    reg [1:0] ctrl_r;
    wire      wdt_en;
    wire      bod_en;

    assign wdt_en = ctrl_r[`RSC_CTRL_WDT_EN_BIT];
    assign bod_en = ctrl_r[`RSC_CTRL_BOD_EN_BIT];

    // software write of enables
    always @(posedge ref_clk)
    begin
        if (rst)
            ctrl_r <= `RSC_CTRL_RST;
        else if (clk_en && reg_wr && reg_addr == `RSC_CTRL_OFS)
            ctrl_r <= reg_wdata[1:0];
    end

    // ------------------------------------------------------------------
    // external pin pulse-width filter
    // ------------------------------------------------------------------
    reg  [7:0] ext_cnt_r;
    wire       ext_req;

    // count consecutive low samples, saturating at the minimum width
    always @(posedge ref_clk)
    begin
        if (rst)
            ext_cnt_r <= 8'h00;
        else if (clk_en)
        begin
            if (ext_n_s)
                ext_cnt_r <= 8'h00;
            else if (ext_cnt_r < EXT_MIN)
                ext_cnt_r <= ext_cnt_r + 8'h01;
        end
    end

    assign ext_req = (ext_cnt_r >= EXT_MIN);

    // ------------------------------------------------------------------
    // brown-out duration filter
    // ------------------------------------------------------------------
    reg  [7:0] bod_cnt_r;
    wire       bod_req;

    // supply must stay low for the minimum period while enabled
    always @(posedge ref_clk)
    begin
        if (rst)
            bod_cnt_r <= 8'h00;
        else if (clk_en)
        begin
            if (!bod_en || !bod_s)
                bod_cnt_r <= 8'h00;
            else if (bod_cnt_r < BOD_MIN)
                bod_cnt_r <= bod_cnt_r + 8'h01;
        end
    end

    assign bod_req = bod_en && (bod_cnt_r >= BOD_MIN);

    // ------------------------------------------------------------------
    // watchdog timeout to one-cycle pulse
    // ------------------------------------------------------------------
    reg  wdt_prev_r;
    wire wdt_pulse;

    // edge detect on the synchronised level
    // only the rising edge counts, so a timeout level left high resets once
    always @(posedge ref_clk)
    begin
        if (rst)
            wdt_prev_r <= 1'b0;
        else if (clk_en)
            wdt_prev_r <= wdt_s;
    end

    assign wdt_pulse = wdt_en && wdt_s && !wdt_prev_r;

    // ------------------------------------------------------------------
    // request combination
    // ------------------------------------------------------------------
    wire [4:0] req_vec;
    wire       req_any;

    // power-on, pin, watchdog, brown-out, scan bit
    assign req_vec = {scan_s, bod_req, wdt_pulse, ext_req, por_s};
    assign req_any = |req_vec;

    // ------------------------------------------------------------------
    // stretch target selection
    // ------------------------------------------------------------------
    reg [CNT_W-1:0] tgt_sel;
    reg [CNT_W-1:0] tgt_r;

    // fuse setting picks the stretch length
    always @*
    begin
        case (delay_select_fuses)
            2'd0:    tgt_sel = DLY_SEL0[CNT_W-1:0];
            2'd1:    tgt_sel = DLY_SEL1[CNT_W-1:0];
            2'd2:    tgt_sel = DLY_SEL2[CNT_W-1:0];
            default: tgt_sel = DLY_SEL3[CNT_W-1:0];
        endcase
    end

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    reg [1:0]       state_r;
    reg [1:0]       state_nxt;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;
    reg [CNT_W-1:0] tgt_nxt;
    reg             sys_reset_nxt;
    reg             fetch_start_nxt;

    // a request seen in any state sends the sequence back to hold, so a
    // glitch during the stretch restarts the whole delay
    // next-state logic of the stretch sequence
    always @*
    begin
        state_nxt       = state_r;
        cnt_nxt         = cnt_r;
        tgt_nxt         = tgt_r;
        sys_reset_nxt   = sys_reset;
        fetch_start_nxt = 1'b0;
        case (state_r)
            ST_HOLD:
            begin
                sys_reset_nxt = 1'b1;
                cnt_nxt       = {CNT_W{1'b0}};
                if (!req_any)
                begin
                    state_nxt = ST_STRETCH;
                    tgt_nxt   = tgt_sel;
                end
            end
            ST_STRETCH:
            begin
                sys_reset_nxt = 1'b1;
                if (req_any)
                begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = {CNT_W{1'b0}};
                end
                else if (cnt_r >= tgt_r - {{(CNT_W-1){1'b0}}, 1'b1})
                begin
                    state_nxt       = ST_RUN;
                    sys_reset_nxt   = 1'b0;
                    fetch_start_nxt = 1'b1;
                    cnt_nxt         = {CNT_W{1'b0}};
                end
                else
                    cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            ST_RUN:
            begin
                sys_reset_nxt = 1'b0;
                if (req_any)
                begin
                    state_nxt     = ST_HOLD;
                    sys_reset_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt     = ST_HOLD;
                sys_reset_nxt = 1'b1;
            end
        endcase
    end

    // sequencer registers, released only on a clock edge
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r     <= ST_HOLD;
            cnt_r       <= {CNT_W{1'b0}};
            tgt_r       <= {CNT_W{1'b0}};
            sys_reset   <= 1'b1;
            fetch_start <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            tgt_r       <= tgt_nxt;
            sys_reset   <= sys_reset_nxt;
            fetch_start <= fetch_start_nxt;
        end
    end

    // ------------------------------------------------------------------
    // port forcing and fetch address
    // ------------------------------------------------------------------
    // port force follows the raw requests, ahead of the stretched reset;
    // it is registered behind the synchronisers, so it trails a pin by
    // about four cycles and needs the clock running
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            io_force   <= 1'b1;
            fetch_addr <= `RSC_RESET_VECTOR;
        end
        else if (clk_en)
        begin
            io_force   <= req_any;
            fetch_addr <= `RSC_RESET_VECTOR;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    reg [31:0] rd_mux;

    // address decode of readable registers
    always @*
    begin
        rd_mux = 32'h00000000;
        if (reg_addr == `RSC_CTRL_OFS)
            rd_mux = {30'h00000000, ctrl_r};
        else if (reg_addr == `RSC_STATUS_OFS)
            rd_mux = {24'h000000, state_r, sys_reset, req_vec};
        else if (reg_addr == `RSC_COUNT_OFS)
            rd_mux = {{(32-CNT_W){1'b0}}, cnt_r};
        else if (reg_addr == `RSC_TARGET_OFS)
            rd_mux = {{(32-CNT_W){1'b0}}, tgt_r};
    end

    // read data stands one cycle after the strobe only
    // zero outside that cycle keeps a stale value off the bus
    always @(posedge ref_clk)
    begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else if (clk_en)
        begin
            if (reg_rd)
                reg_rdata <= rd_mux;
            else
                reg_rdata <= 32'h00000000;
        end
    end

endmodule

/* rsc_reset_ctrl_chk.sv */
`timescale 1ns/1ps
`include "rsc_map.vh"

module rsc_reset_ctrl_chk
#(
    parameter DLY_SEL0 = 16,
    parameter DLY_SEL1 = 1024,
    parameter DLY_SEL2 = 16384,
    parameter DLY_SEL3 = 65536
)
(
    // clock, reset, enable
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    // requests and fuses
    input wire logic        por_below,
    input wire logic        ext_reset_n,
    input wire logic        wdt_timeout,
    input wire logic        bod_below,
    input wire logic        scan_reset_bit,
    input wire logic [1:0]  delay_select_fuses,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // reset outputs
    input wire logic        sys_reset,
    input wire logic        io_force,
    input wire logic        fetch_start,
    input wire logic [15:0] fetch_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [1:0] en_r;
    int         cnt_r;
    int         bod_r;
    int         tgt;
    // selected stretch length
    assign tgt = delay_select_fuses == 2'h0 ? DLY_SEL0 : delay_select_fuses == 2'h1 ? DLY_SEL1 :
                 delay_select_fuses == 2'h2 ? DLY_SEL2 : DLY_SEL3;
    // track enables, stretch cycles and low-supply run
    always @(posedge ref_clk)
    begin
        if (rst)
            en_r <= 2'h0;
        else if (clk_en && reg_wr && reg_addr == `RSC_CTRL_OFS)
            en_r <= reg_wdata[1:0];
        cnt_r <= (rst || io_force || !sys_reset) ? 0 : cnt_r + 1;
        bod_r <= (rst || !(bod_below && en_r[1])) ? 0 : (bod_r > 60 ? bod_r : bod_r + 1);
    end
    sequence quiet_s;
        !sys_reset && !en_r[0] && !por_below && ext_reset_n && !bod_below && !scan_reset_bit;
    endsequence
    sequence pin_low_s;
        !ext_reset_n [*2];
    endsequence
    por_hold_a: assert property (por_below |-> ##[1:5] (sys_reset && io_force))
        else $error("power-on request not followed by reset");
    pin_req_a: assert property (pin_low_s |-> ##[1:5] io_force)
        else $error("pin low not followed by forcing");
    scan_hold_a: assert property (scan_reset_bit |-> ##[1:5] sys_reset)
        else $error("scan bit not followed by reset");
    force_hold_a: assert property (io_force |=> sys_reset)
        else $error("reset dropped while a request stood");
    rel_fetch_a: assert property ($fell(sys_reset) |-> fetch_start && fetch_addr == 16'h0000)
        else $error("release without fetch at the vector");
    fetch_once_a: assert property (fetch_start |=> !fetch_start && !sys_reset)
        else $error("fetch pulse not single");
    stretch_len_a: assert property ($fell(sys_reset) |-> cnt_r + 1 >= tgt && cnt_r <= tgt + 1)
        else $error("stretch length off");
    bod_long_a: assert property (bod_r == 48 |-> sys_reset)
        else $error("long brown-out without reset");
    wdt_gate_a: assert property (quiet_s [*6] |=> !sys_reset)
        else $error("reset with no enabled request");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_chk #(.DLY_SEL0(DLY_SEL0), .DLY_SEL1(DLY_SEL1),
    .DLY_SEL2(DLY_SEL2), .DLY_SEL3(DLY_SEL3)) chk_i (.*);

/* rsc_src_model.sv */
`timescale 1ns/1ps

module rsc_src_model
(
    // clock
    input  wire logic ref_clk,
    // request sources
    output logic      por_below,
    output logic      ext_reset_n,
    output logic      wdt_timeout,
    output logic      bod_below,
    output logic      scan_reset_bit
);
    // supply starts low, pin pulled high
    initial
    begin
        por_below      = 1'b1;
        ext_reset_n    = 1'b1;
        wdt_timeout    = 1'b0;
        bod_below      = 1'b0;
        scan_reset_bit = 1'b0;
    end
    // set one source active or idle
    task automatic drv(input int s, input bit a);
        case (s)
            0: por_below <= a;
            1: ext_reset_n <= !a;
            2: wdt_timeout <= a;
            3: bod_below <= a;
            default: scan_reset_bit <= a;
        endcase
    endtask
    // hold one source active for n cycles
    task automatic hold(input int s, input int n);
        @(posedge ref_clk);
        drv(s, 1'b1);
        repeat (n) @(posedge ref_clk);
        drv(s, 1'b0);
    endtask
endmodule

/* rsc_reset_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "rsc_map.vh"

module rsc_reset_ctrl_tb_top;
    logic        ref_clk;
    logic        rst;
    logic        clk_en;
    wire         por_below;
    wire         ext_reset_n;
    wire         wdt_timeout;
    wire         bod_below;
    wire         scan_reset_bit;
    logic [1:0]  delay_select_fuses;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    wire  [31:0] reg_rdata;
    wire         sys_reset;
    wire         io_force;
    wire         fetch_start;
    wire  [15:0] fetch_addr;
    logic        rd_d;
    int          n_fail;
    int          samples_checked;
    int          cyc;
    int          dly [4] = '{4, 8, 12, 16};
    logic [31:0] wd;
    logic [31:0] rd_q [$];
    int          fs_q [$];

    rsc_reset_ctrl #(.DLY_SEL0(4), .DLY_SEL1(8), .DLY_SEL2(12), .DLY_SEL3(16))
    rsc_reset_ctrl_i
    (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .clk_en             (clk_en),
        .por_below          (por_below),
        .ext_reset_n        (ext_reset_n),
        .wdt_timeout        (wdt_timeout),
        .bod_below          (bod_below),
        .scan_reset_bit     (scan_reset_bit),
        .delay_select_fuses (delay_select_fuses),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .sys_reset          (sys_reset),
        .io_force           (io_force),
        .fetch_start        (fetch_start),
        .fetch_addr         (fetch_addr)
    );
    rsc_src_model rsc_src_model_i
    (
        .ref_clk        (ref_clk),
        .por_below      (por_below),
        .ext_reset_n    (ext_reset_n),
        .wdt_timeout    (wdt_timeout),
        .bod_below      (bod_below),
        .scan_reset_bit (scan_reset_bit)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task summarize;
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // -------------------------------------------------------------
    // register port and request drivers
    // -------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        rd_q.push_back(e);
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask
    // pulse a source, then wait for the block to settle in run
    task automatic go(input int s, input int n, input bit e);
        int i;
        if (e)
            fs_q.push_back(1);
        rsc_src_model_i.hold(s, n);
        repeat (8) @(negedge ref_clk);
        i = 0;
        while ((sys_reset !== 1'b0 || fs_q.size() != 0) && i < 400)
        begin
            @(negedge ref_clk);
            i++;
        end
        chk(fs_q.size() + sys_reset, 32'h0);
    endtask

    // compare read data and release pulses against the notes
    always @(posedge ref_clk)
    begin
        rd_d <= reg_rd;
        cyc  <= cyc + 1;
        if (rd_d)
            chk(reg_rdata, rd_q.pop_front());
        if (fetch_start === 1'b1)
        begin
            chk(fs_q.size(), 32'h1);
            chk({16'h0, fetch_addr}, {16'h0, `RSC_RESET_VECTOR});
            if (fs_q.size() > 0)
                void'(fs_q.pop_front());
        end
        if (cyc == 6000)
        begin
            n_fail++;
            summarize();
        end
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        void'($urandom(86));
        rst = 1'b1;
        clk_en = 1'b1;
        delay_select_fuses = 2'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_d = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int f = 0; f < 4; f++)
        begin
            delay_select_fuses <= f[1:0];
            go(0, 2 + $urandom % 6, 1);
            rd(`RSC_TARGET_OFS, dly[f]);
            rd(`RSC_STATUS_OFS, 32'h80);
        end
        delay_select_fuses <= 2'h0;
        wd = $urandom;
        wr(`RSC_CTRL_OFS, {wd[31:2], 2'h0});
        rd(`RSC_CTRL_OFS, 32'h0);
        rd(8'h10, 32'h0);
        go(2, 3, 0);
        go(3, 60, 0);
        wr(`RSC_CTRL_OFS, wd | 32'h3);
        rd(`RSC_CTRL_OFS, 32'h3);
        go(3, 20, 0);
        go(3, 60, 1);
        go(2, 3, 1);
        go(1, 2 + $urandom % 4, 1);
        go(4, 10, 1);
        delay_select_fuses <= 2'h3;
        rsc_src_model_i.hold(0, 3);
        repeat (6) @(posedge ref_clk);
        go(4, 3, 1);
        repeat (4) @(posedge ref_clk);
        summarize();
    end
endmodule
